/* File: hw/apcp_parser.sv */
// target-side ascii packet parser and reply builder
// How it works
// - unit address loads only when 1 to 9999
// - reply echoes the address digits the controller used, zero padded on the left to four characters
// - forward slash separates address and code both ways
// - code is exactly three letters
// - upper and lower case code letters both accepted
// - set qualifier hands argument characters to the parameter back end
// - query answered with code, set qualifier and present value
// - valid set acknowledged with code and set qualifier only
// - invalid set value answered with code and query qualifier
// - unknown code answered with code and exclamation mark
// - wrong mode answered with code and asterisk, no change
// - busy hardware answered with code and hash
// - arguments are digits, period and comma, possibly none
// - reply ends with carriage return then line feed
// - controller packets start with less-than, replies greater-than
// - characters are 8N1 at 2400 to 38400 baud
// - multi-drop address zero is acted on with no reply
module apcp_parser
  import apcp_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       tx_ready_i,
  output logic            tx_valid_o,
  output logic [7:0]      tx_data_o,
  input  wire logic       addr_load_i,
  input  wire logic [13:0] addr_value_i,
  input  wire logic       multidrop_i,
  output logic [13:0]     unit_addr_o,
  output logic            req_valid_o,
  output apcp_req_t       req_o,
  input  wire logic       resp_valid_i,
  input  wire apcp_resp_t resp_i
);
  // ==========================================
  // state
  apcp_state_t     state;
  logic [13:0]     addr_val;
  logic [3:0][7:0] addr_txt;
  logic [2:0]      addr_n;
  logic [2:0][7:0] code;
  logic [1:0]      code_n;
  logic            is_set;
  logic [7:0][7:0] args;
  logic [3:0]      arg_n;
  logic            arg_bad;
  logic            bcast;
  logic [7:0]      rqual;
  logic [3:0]      rvlen;
  logic [7:0][7:0] rval;
  logic [4:0]      pos;
  logic            v1;
  logic [7:0]      d1;
  logic [7:0]      gen_char;
  logic [2:0][7:0] code_up;
  logic [2:0]      up_ok;

  // decoded rx byte classes
  wire       rx_dig   = rx_data_i >= CH_0 && rx_data_i <= CH_9;
  wire       rx_up    = rx_data_i >= CH_UA && rx_data_i <= CH_UZ;
  wire       rx_lo    = rx_data_i >= CH_LA && rx_data_i <= CH_LZ;
  wire       rx_arg   = rx_dig || rx_data_i == CH_DOT || rx_data_i == CH_COMMA;
  wire       rx_sop   = rx_valid_i && rx_data_i == CH_SOP;
  wire       parsing  = state inside {PS_ADDR, PS_CODE, PS_QUAL, PS_ARGS};
  wire       bc_now   = multidrop_i && addr_val == 14'h0000;
  wire       addr_hit = addr_val == unit_addr_o || bc_now;
  wire       eop      = state == PS_ARGS && rx_valid_i && rx_data_i == CH_CR;
  wire       loc_bad  = is_set && arg_bad;
  wire       take     = state == PS_EXEC && resp_valid_i;
  wire       push     = state == PS_REPLY && !v1;
  wire [4:0] pos_cr   = POS_VAL + {1'b0, rvlen};
  wire       last     = pos == pos_cr + 5'h01;
  wire [13:0] addr_nx = 14'(addr_val * ADDR_TEN) + 14'(rx_data_i[3:0]);

  // ==========================================
  // unit address, kept inside the legal range at all times
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      unit_addr_o <= ADDR_RST;
    end else if (addr_load_i && addr_value_i >= ADDR_MIN && addr_value_i <= ADDR_MAX) begin
      unit_addr_o <= addr_value_i;
    end
  end

  // ==========================================
  // packet parser
  // rx bytes arriving during exec or reply are dropped: the controller
  // only speaks again after a complete reply
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state    <= PS_IDLE;
      addr_val <= 14'h0000;
      addr_txt <= {4{CH_0}};
      addr_n   <= 3'h0;
      code     <= '0;
      code_n   <= 2'h0;
      is_set   <= 1'b0;
      args     <= '0;
      arg_n    <= 4'h0;
      arg_bad  <= 1'b0;
      bcast    <= 1'b0;
    end else if (rx_sop && (state == PS_IDLE || parsing)) begin
      state    <= PS_ADDR;
      addr_val <= 14'h0000;
      addr_txt <= {4{CH_0}};
      addr_n   <= 3'h0;
      code_n   <= 2'h0;
      arg_n    <= 4'h0;
      arg_bad  <= 1'b0;
    end else begin
      case (state)
        PS_ADDR: begin
          if (rx_valid_i) begin
            if (rx_dig && addr_n < ADDR_DIG) begin
              addr_val <= addr_nx;
              addr_txt <= {addr_txt[2:0], rx_data_i};
              addr_n   <= addr_n + 3'h1;
            end else if (rx_data_i == CH_DLM && addr_n != 3'h0 && addr_hit) begin
              state <= PS_CODE;
              bcast <= bc_now;
            end else begin
              state <= PS_IDLE;
            end
          end
        end
        PS_CODE: begin
          if (rx_valid_i) begin
            if (rx_up || rx_lo) begin
              code[code_n] <= rx_data_i;
              code_n       <= code_n + 2'h1;
              if (code_n == 2'h2) begin
                state <= PS_QUAL;
              end
            end else begin
              state <= PS_IDLE;
            end
          end
        end
        PS_QUAL: begin
          if (rx_valid_i) begin
            if (rx_data_i == CH_SET || rx_data_i == CH_QRY) begin
              is_set <= rx_data_i == CH_SET;
              state  <= PS_ARGS;
            end else begin
              state <= PS_IDLE;
            end
          end
        end
        PS_ARGS: begin
          if (eop) begin
            if (!loc_bad) begin
              state <= PS_EXEC;
            end else begin
              state <= bcast ? PS_IDLE : PS_REPLY;
            end
          end else if (rx_valid_i) begin
            if (rx_arg && arg_n < ARG_MAX) begin
              args[arg_n[2:0]] <= rx_data_i;
              arg_n            <= arg_n + 4'h1;
            end else begin
              arg_bad <= 1'b1;
            end
          end
        end
        PS_EXEC: begin
          if (resp_valid_i) begin
            state <= bcast ? PS_IDLE : PS_REPLY;
          end
        end
        PS_REPLY: begin
          if (push && last) begin
            state <= PS_IDLE;
          end
        end
        default: begin
          state <= PS_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // upper-case copy of the code for the back end
  for (genvar i = 0; i < 3; i++) begin : g_up
    assign code_up[i] = (code[i] >= CH_LA) ? code[i] - CASE_BIT : code[i];
    assign up_ok[i]   = code_up[i] >= CH_UA && code_up[i] <= CH_UZ;
  end

  // ==========================================
  // request to the parameter back end, held until it answers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_valid_o <= 1'b0;
      req_o       <= '0;
    end else if (eop && !loc_bad) begin
      req_valid_o <= 1'b1;
      req_o       <= '{code: code_up, is_set: is_set, arg_len: arg_n, args: args, bcast: bcast};
    end else if (take) begin
      req_valid_o <= 1'b0;
    end
  end

  // ==========================================
  // reply qualifier and value from the answer
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rqual <= CH_SET;
      rvlen <= 4'h0;
      rval  <= '0;
    end else if (eop && loc_bad) begin
      rqual <= CH_QRY;
      rvlen <= 4'h0;
    end else if (take) begin
      rvlen <= 4'h0;
      rval  <= resp_i.val;
      case (resp_i.stat)
        RS_OK: begin
          rqual <= CH_SET;
          if (!is_set) begin
            rvlen <= (resp_i.val_len > ARG_MAX) ? ARG_MAX : resp_i.val_len;
          end
        end
        RS_BADVAL: rqual <= CH_QRY;
        RS_MODE:   rqual <= CH_MODE;
        RS_BUSY:   rqual <= CH_BUSY;
        default:   rqual <= CH_UNK;
      endcase
    end
  end

  // ==========================================
  // reply character position
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pos <= 5'h00;
    end else if (state != PS_REPLY) begin
      pos <= 5'h00;
    end else if (push) begin
      pos <= pos + 5'h01;
    end
  end

  // reply character for the current position
  always_comb begin
    gen_char = CH_LF;
    if (pos == 5'h00) begin
      gen_char = CH_RSP;
    end else if (pos <= 5'h04) begin
      gen_char = addr_txt[2'(5'h04 - pos)];
    end else if (pos == 5'h05) begin
      gen_char = CH_DLM;
    end else if (pos <= 5'h08) begin
      gen_char = code[2'(pos - 5'h06)];
    end else if (pos == 5'h09) begin
      gen_char = rqual;
    end else if (pos < pos_cr) begin
      gen_char = rval[3'(pos - POS_VAL)];
    end else if (pos == pos_cr) begin
      gen_char = CH_CR;
    end
  end

  // ==========================================
  // two-entry transmit buffer; a full buffer stalls the reply builder,
  // so the uart may hold tx_ready_i low without losing a character
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
      v1         <= 1'b0;
      d1         <= 8'h00;
    end else if (tx_valid_o && tx_ready_i) begin
      if (v1) begin
        tx_data_o <= d1;
        v1        <= 1'b0;
      end else begin
        tx_valid_o <= push;
        tx_data_o  <= gen_char;
      end
    end else if (push) begin
      if (!tx_valid_o) begin
        tx_valid_o <= 1'b1;
        tx_data_o  <= gen_char;
      end else begin
        v1 <= 1'b1;
        d1 <= gen_char;
      end
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_take(apcp_stat_t st);
    take && resp_i.stat == st && !bcast;
  endsequence

  property p_addr_range;
    unit_addr_o >= ADDR_MIN && unit_addr_o <= ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("unit address out of range");

  property p_echo_addr;
    push && pos == 5'h01 |-> gen_char == addr_txt[3] ##1 pos == 5'h02;
  endproperty
  a_echo_addr: assert property (p_echo_addr) else $error("address echo wrong");

  property p_delim;
    push && pos == 5'h05 |-> gen_char == CH_DLM;
  endproperty
  a_delim: assert property (p_delim) else $error("delimiter missing");

  property p_upper;
    $rose(req_valid_o) |-> &up_ok;
  endproperty
  a_upper: assert property (p_upper) else $error("code not upper case");

  property p_query;
    s_take(RS_OK) ##0 (!is_set && resp_i.val_len <= ARG_MAX) |=>
      rqual == CH_SET && rvlen == $past(resp_i.val_len) && state == PS_REPLY;
  endproperty
  a_query: assert property (p_query) else $error("query reply wrong");

  property p_ack;
    s_take(RS_OK) ##0 is_set |=> rqual == CH_SET && rvlen == 4'h0 && !req_valid_o;
  endproperty
  a_ack: assert property (p_ack) else $error("set ack wrong");

  property p_bad;
    (take && resp_i.stat == RS_BADVAL && !bcast) || (eop && loc_bad && !bcast) |=>
      rqual == CH_QRY && rvlen == 4'h0;
  endproperty
  a_bad: assert property (p_bad) else $error("invalid value reply wrong");

  property p_unk;
    s_take(RS_UNKNOWN) |=> rqual == CH_UNK && rvlen == 4'h0;
  endproperty
  a_unk: assert property (p_unk) else $error("unknown code reply wrong");

  property p_mode;
    s_take(RS_MODE) |=> rqual == CH_MODE && rvlen == 4'h0;
  endproperty
  a_mode: assert property (p_mode) else $error("wrong mode reply wrong");

  property p_busy;
    s_take(RS_BUSY) |=> rqual == CH_BUSY && rvlen == 4'h0;
  endproperty
  a_busy: assert property (p_busy) else $error("busy reply wrong");

  property p_crlf;
    push && pos == pos_cr |-> gen_char == CH_CR ##[1:1000] (push && gen_char == CH_LF && last);
  endproperty
  a_crlf: assert property (p_crlf) else $error("reply not ended by cr lf");

  property p_bcast;
    take && bcast |=> state == PS_IDLE && !push;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast answered");

  property p_restart;
    rx_sop && parsing |=> state == PS_ADDR && addr_n == 3'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("start char did not restart");
endmodule : apcp_parser

/* File: hw/apcp_pkg.sv */
// shared constants and types for the ascii packet command parser
package apcp_pkg;
  // ==========================================
  // packet characters
  localparam logic [7:0] CH_SOP   = 8'h3C; // controller start '<'
  localparam logic [7:0] CH_RSP   = 8'h3E; // reply start '>'
  localparam logic [7:0] CH_DLM   = 8'h2F; // address delimiter '/'
  localparam logic [7:0] CH_SET   = 8'h3D; // set_qualifier '='
  localparam logic [7:0] CH_QRY   = 8'h3F; // query_qualifier '?'
  localparam logic [7:0] CH_UNK   = 8'h21; // unknown code '!'
  localparam logic [7:0] CH_MODE  = 8'h2A; // wrong mode '*'
  localparam logic [7:0] CH_BUSY  = 8'h23; // hardware busy '#'
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_DOT   = 8'h2E;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_9     = 8'h39;
  localparam logic [7:0] CH_UA    = 8'h41; // 'A'
  localparam logic [7:0] CH_UZ    = 8'h5A; // 'Z'
  localparam logic [7:0] CH_LA    = 8'h61; // 'a'
  localparam logic [7:0] CH_LZ    = 8'h7A; // 'z'
  localparam logic [7:0] CASE_BIT = 8'h20; // lower minus upper

  // ==========================================
  // address and field sizes
  localparam logic [13:0] ADDR_MIN = 14'h0001;
  localparam logic [13:0] ADDR_MAX = 14'h270F; // 9999
  localparam logic [13:0] ADDR_RST = 14'h0001;
  localparam logic [13:0] ADDR_TEN = 14'h000A;
  localparam logic [2:0]  ADDR_DIG = 3'h4;
  localparam logic [3:0]  ARG_MAX  = 4'h8;
  localparam logic [4:0]  POS_VAL  = 5'h0A; // first value char of a reply

  // ==========================================
  // types
  typedef enum logic [2:0] {
    RS_OK      = 3'b000,
    RS_BADVAL  = 3'b001,
    RS_UNKNOWN = 3'b010,
    RS_MODE    = 3'b011,
    RS_BUSY    = 3'b100
  } apcp_stat_t;

  typedef enum logic [2:0] {
    PS_IDLE  = 3'b000,
    PS_ADDR  = 3'b001,
    PS_CODE  = 3'b010,
    PS_QUAL  = 3'b011,
    PS_ARGS  = 3'b100,
    PS_EXEC  = 3'b101,
    PS_REPLY = 3'b110
  } apcp_state_t;

  typedef struct packed {
    logic [2:0][7:0] code;    // upper case, code[0] first
    logic            is_set;
    logic [3:0]      arg_len;
    logic [7:0][7:0] args;    // args[0] first
    logic            bcast;
  } apcp_req_t;

  typedef struct packed {
    apcp_stat_t      stat;
    logic [3:0]      val_len;
    logic [7:0][7:0] val;     // val[0] first
  } apcp_resp_t;
endpackage : apcp_pkg

/* File: tb/apcp_host.sv */
// host controller model: sends command packets and collects reply bytes
module apcp_host
  import apcp_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       slow_i,
  input  wire logic       dut_tx_valid_i,
  input  wire logic [7:0] dut_tx_data_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // reply capture
  logic [127:0] rep;
  int           nbytes;
  logic [1:0]   cnt;

  // non-blocking like every other write to these, so no variable mixes both kinds
  initial begin
    rx_valid_o <= 1'b0;
    rx_data_o  <= 8'h00;
    tx_ready_o <= 1'b0;
    rep        <= '0;
    nbytes     <= 0;
    cnt        <= '0;
  end

  // ready one cycle in three when slow, so the two-entry buffer fills and stalls
  always @(posedge clk_sys_i) begin
    cnt        <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
    tx_ready_o <= !slow_i || (cnt == 2'h0);
    if (dut_tx_valid_i && tx_ready_o) begin
      rep    <= {rep[119:0], dut_tx_data_i};
      nbytes <= nbytes + 1;
    end
  end

  // ==========================================
  // sending: one char per cycle, packet closed by a single carriage return
  task automatic send(input string s);
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge clk_sys_i);
      rx_valid_o <= 1'b1;
      rx_data_o  <= (i == s.len()) ? CH_CR : s[i];
    end
    @(posedge clk_sys_i);
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~rx_data_o; // idle line must not look like the last char
  endtask : send

  task automatic clr();
    rep    <= '0;
    nbytes <= 0;
  endtask : clr
endmodule : apcp_host

/* File: tb/tb.sv */
// self-checking bench for the ascii packet command parser
module tb
  import apcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  logic        clk_sys_i    = 1'b0;
  logic        sys_rst_i    = 1'b1;
  logic        rx_valid_i;
  logic [7:0]  rx_data_i;
  logic        tx_ready_i;
  logic        tx_valid_o;
  logic [7:0]  tx_data_o;
  logic        addr_load_i  = 1'b0;
  logic [13:0] addr_value_i = 14'h0000;
  logic        multidrop_i  = 1'b0;
  logic [13:0] unit_addr_o;
  logic        req_valid_o;
  apcp_req_t   req_o;
  logic        resp_valid_i = 1'b0;
  apcp_resp_t  resp_i       = '0;
  logic        slow         = 1'b0;
  int          error_cnt    = 0;
  int          tests_run    = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  apcp_parser u_apcp_parser (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .addr_load_i(addr_load_i), .addr_value_i(addr_value_i), .multidrop_i(multidrop_i),
    .unit_addr_o(unit_addr_o), .req_valid_o(req_valid_o), .req_o(req_o),
    .resp_valid_i(resp_valid_i), .resp_i(resp_i)
  );

  apcp_host u_apcp_host (
    .clk_sys_i(clk_sys_i), .slow_i(slow), .dut_tx_valid_i(tx_valid_o), .dut_tx_data_i(tx_data_o),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i)
  );

  // ==========================================
  // shared helpers
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic hang(input string what);
    error_cnt++;
    $display("[FAIL] %s expected done seen timeout", what);
    close_out();
  endtask : hang

  // expected reply bytes, right-aligned, with the closing return and feed
  function automatic logic [127:0] pk(input string s);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < s.len(); i++) r = {r[119:0], s[i]};
    return {r[111:0], CH_CR, CH_LF};
  endfunction : pk

  // back end: wait for the request, compare it, answer with one status pulse
  task automatic serve(input string c, input bit set, input string a, input apcp_stat_t st,
                       input string v, input bit bc);
    apcp_resp_t r;
    string      u;
    int         n;
    n = 0;
    u = c.toupper();
    while (req_valid_o !== 1'b1) begin
      @(posedge clk_sys_i);
      if (++n > 200) hang("request");
    end
    check("req set", req_o.is_set, set);
    check("req len", req_o.arg_len, a.len());
    check("req bcast", req_o.bcast, bc);
    for (int i = 0; i < 3; i++) check("req code", req_o.code[i], u[i]);
    for (int i = 0; i < a.len(); i++) check("req arg", req_o.args[i], a[i]);
    r = '0;
    r.stat = st;
    r.val_len = 4'(v.len());
    for (int i = 0; i < v.len(); i++) r.val[i] = v[i];
    resp_valid_i <= 1'b1;
    resp_i       <= r;
    @(posedge clk_sys_i);
    resp_valid_i <= 1'b0;
  endtask : serve

  // collect one reply, ended only by the return and feed pair
  task automatic reply(input string e, input bit noreq);
    int n;
    n = 0;
    while (!(u_apcp_host.nbytes >= 2 && u_apcp_host.rep[15:0] === 16'h0D0A)) begin
      @(posedge clk_sys_i);
      if (noreq && req_valid_o === 1'b1) check("no request", 1'b1, 1'b0);
      if (++n > 400) hang("reply");
    end
    check("reply", u_apcp_host.rep, pk(e));
    u_apcp_host.clr();
  endtask : reply

  task automatic quiet(input bit noreq);
    repeat (60) begin
      @(posedge clk_sys_i);
      if (tx_valid_o === 1'b1 || (noreq && req_valid_o === 1'b1)) check("silent", 1'b1, 1'b0);
    end
  endtask : quiet

  // ==========================================
  // scenarios
  task automatic t_addr();
    logic [13:0] ld [4];
    logic [13:0] ex [4];
    ld = '{14'h0000, 14'h2710, 14'h270F, 14'h000C};
    ex = '{14'h0001, 14'h0001, 14'h270F, 14'h000C};
    check("unit addr", unit_addr_o, 14'h0001);
    check("tx idle", tx_valid_o, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      addr_load_i  <= 1'b1;
      addr_value_i <= ld[i];
      @(posedge clk_sys_i);
      addr_load_i <= 1'b0;
      @(posedge clk_sys_i);
      check("unit addr", unit_addr_o, ex[i]);
    end
  endtask : t_addr

  // query under a stalling receiver; short address echoed zero padded
  task automatic t_query();
    slow <= 1'b1;
    u_apcp_host.send("<12/abc?");
    serve("abc", 1'b0, "", RS_OK, "5,1", 1'b0);
    reply(">0012/abc=5,1", 1'b0);
    slow <= 1'b0;
  endtask : t_query

  task automatic t_set();
    apcp_stat_t st [5];
    string      q;
    st = '{RS_OK, RS_BADVAL, RS_UNKNOWN, RS_MODE, RS_BUSY};
    q = "=?!*#";
    for (int i = 0; i < 5; i++) begin
      u_apcp_host.send("<12/Mut=12.5");
      serve("Mut", 1'b1, "12.5", st[i], "", 1'b0);
      reply({">0012/Mut", q.substr(i, i)}, 1'b0);
    end
    // a busy answer is resent and then accepted
    u_apcp_host.send("<0012/MUT=1,0");
    serve("MUT", 1'b1, "1,0", RS_BUSY, "", 1'b0);
    reply(">0012/MUT#", 1'b0);
    u_apcp_host.send("<0012/MUT=1,0");
    serve("MUT", 1'b1, "1,0", RS_OK, "", 1'b0);
    reply(">0012/MUT=", 1'b0);
  endtask : t_set

  // bad argument chars and too many args: error reply, back end untouched
  task automatic t_badarg();
    u_apcp_host.send("<12/MUT=1A");
    reply(">0012/MUT?", 1'b1);
    u_apcp_host.send("<12/MUT=123456789");
    reply(">0012/MUT?", 1'b1);
  endtask : t_badarg

  task automatic t_drop();
    u_apcp_host.send("<12/AB1?");
    quiet(1'b1);
    u_apcp_host.send("<13/ABC?");
    quiet(1'b1);
    u_apcp_host.send("<12/AB<12/xyz?");
    serve("xyz", 1'b0, "", RS_UNKNOWN, "", 1'b0);
    reply(">0012/xyz!", 1'b0);
  endtask : t_drop

  task automatic t_bcast();
    u_apcp_host.send("<0/MUT=1");
    quiet(1'b1);
    multidrop_i <= 1'b1;
    u_apcp_host.send("<0/MUT=1");
    serve("MUT", 1'b1, "1", RS_OK, "", 1'b1);
    quiet(1'b0);
    multidrop_i <= 1'b0;
  endtask : t_bcast

  // ==========================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_addr();
    t_query();
    t_set();
    t_badarg();
    t_drop();
    t_bcast();
    close_out();
  end
endmodule : tb
